//--- verilog/uedm_pkg.sv
// Shared constants, types and helpers for the serial event timing block
package uedm_pkg;
   // Clock and line rate
   localparam int CLK_HZ             = 250_000_000;
   localparam int BAUD_DEFAULT       = 115_200;
   localparam int OVERSAMPLE         = 16;
   localparam int SAMPLE_DIV_DEFAULT = CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT);

   // Tick counter positions within one bit period
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] MID_TICK  = 4'h7;
   localparam logic [3:0] TICK_ZERO = 4'h0;

   // Character frame
   localparam int         DATA_BITS = 8;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [2:0] BIT_ZERO  = 3'h0;

   // Receive interrupt timing in sample ticks after the stop bit begins
   localparam int RX_INT_MAX_TICKS   = 17;
   localparam int RX_FIFO_TRIG_TICKS = 19;
   localparam int STOP_SAMPLE_TICKS  = 8;
   localparam logic [4:0] RX_DLY_PLAIN = 5'h01;
   localparam logic [4:0] RX_DLY_FIFO  =
      5'(RX_FIFO_TRIG_TICKS - STOP_SAMPLE_TICKS);
   localparam logic [4:0] DLY_ZERO     = 5'h00;

   // Transmit FIFO depth
   localparam int FIFO_DEPTH = 16;

   // Modem status layout: deltas low, current levels high
   localparam int MODEM_DELTA_LSB = 0;
   localparam int MODEM_LEVEL_LSB = 4;
   localparam logic [7:0] MODEM_RESET = 8'h00;

   // Line state machine, Gray coded along idle-start-data-stop
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } uedm_line_state_t;

   // Receive DMA signalling uses mode 1 only with FIFO on and mode bit set
   function automatic logic uedm_rx_mode1(input logic fe, input logic dms);
      return fe & dms;
   endfunction

   // Transmit DMA signalling follows the mode bit alone
   function automatic logic uedm_tx_mode1(input logic fe, input logic dms);
      return dms | (fe & dms);
   endfunction
endpackage

//--- verilog/uedm_fifo_if.sv
// Valid/ready carrier between the top module and its FIFO
`timescale 1ns/1ps
interface uedm_fifo_if #(parameter int W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface

//--- verilog/uedm_fifo.sv
// Parameterised FIFO with a registered output stage
`timescale 1ns/1ps
module uedm_fifo
#(
   parameter int W     = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   uedm_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;
   logic          not_full_r;
   logic          out_valid_r;
   logic [W-1:0]  out_data_r;

   wire push    = f.in_valid & not_full_r;
   wire stage_ok = ~out_valid_r | f.out_ready;
   wire pop     = stage_ok & (count_r != '0);
   wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

   assign f.in_ready  = not_full_r;
   assign f.out_valid = out_valid_r;
   assign f.out_data  = out_data_r;

   ////////////////////////////////////////////////////////////////////
   // Storage array, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= f.in_data;
      end
   end

   // Pointers, fill level and output stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         count_r     <= '0;
         not_full_r  <= 1'b1;
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end
      else
      begin
         count_r    <= count_nxt;
         not_full_r <= (count_nxt != (AW+1)'(DEPTH)); // Honest full
         if (push)
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         if (pop)
         begin
            rd_ptr_r    <= AW'(rd_ptr_r + 1'b1);
            out_data_r  <= mem_r[rd_ptr_r];
            out_valid_r <= 1'b1;
         end
         else if (f.out_ready)
            out_valid_r <= 1'b0;
      end
   end
endmodule // uedm_fifo

//--- verilog/uedm_top.sv
// Serial element: 16x receiver, FIFO transmitter, DMA modes, modem status
`timescale 1ns/1ps
module uedm_top
#(
   parameter int SAMPLE_DIV = uedm_pkg::SAMPLE_DIV_DEFAULT
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       rxd,
   output logic            txd,
   input  wire logic       tx_wr,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   input  wire logic       rx_rd,
   output logic [7:0]      rx_data,
   output logic            rx_overrun,
   input  wire logic       modem_status_rd,
   input  wire logic [3:0] modem_in,
   output logic [7:0]      modem_status_register,
   input  wire logic       fifo_enable_bit,
   input  wire logic       dma_mode_select_bit,
   output logic            rx_irq,
   output logic            transmit_holding_empty,
   output logic            modem_irq,
   output logic            rxrdy_n,
   output logic            txrdy_n
);
   import uedm_pkg::*;

   localparam int DW = $clog2(SAMPLE_DIV);

   ////////////////////////////////////////////////////////////////////
   // Sixteen-times-baud tick shared by receiver and transmitter
   logic [DW-1:0] div_cnt_r;
   wire sample_tick = (div_cnt_r == DW'(SAMPLE_DIV - 1));
   wire transmit_shift_clock = sample_tick;

   always_ff @(posedge clk)
   begin
      if (rst || sample_tick)
         div_cnt_r <= '0;
      else
         div_cnt_r <= DW'(div_cnt_r + 1'b1);
   end

   ////////////////////////////////////////////////////////////////////
   // Receiver
   uedm_line_state_t rx_st_r;
   logic [3:0]       rx_tick_r;
   logic [2:0]       rx_bit_r;
   logic [7:0]       rx_shift_r;
   logic [7:0]       rx_data_r;
   logic             rx_full_r;
   logic             rx_ovr_r;
   logic [4:0]       rx_dly_r;
   logic             rx_dly_run_r;
   logic             rx_irq_r;

   wire rx_at_mid   = sample_tick & (rx_tick_r == MID_TICK);
   wire rx_at_last  = sample_tick & (rx_tick_r == TICK_LAST);
   wire rx_stop_hit = (rx_st_r == ST_STOP) & rx_at_last;
   wire rx_first    = fifo_enable_bit & ~rx_full_r;
   wire rx_dly_done = rx_dly_run_r & sample_tick & (rx_dly_r == RX_DLY_PLAIN);

   // Bit framing: confirm start at half bit, then sample every 16 ticks
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_st_r    <= ST_IDLE;
         rx_tick_r  <= TICK_ZERO;
         rx_bit_r   <= BIT_ZERO;
         rx_shift_r <= 8'h00;
      end
      else
      begin
         if (sample_tick)
            rx_tick_r <= 4'(rx_tick_r + 1'b1);
         case (rx_st_r)
            ST_IDLE:
               if (~rxd)
               begin
                  rx_st_r   <= ST_START;
                  rx_tick_r <= TICK_ZERO;
               end
            ST_START:
               if (rx_at_mid)
               begin
                  rx_st_r   <= rxd ? ST_IDLE : ST_DATA;
                  rx_tick_r <= TICK_ZERO;
                  rx_bit_r  <= BIT_ZERO;
               end
            ST_DATA:
               if (rx_at_last)
               begin
                  rx_shift_r <= {rxd, rx_shift_r[7:1]};
                  rx_bit_r   <= 3'(rx_bit_r + 1'b1);
                  if (rx_bit_r == LAST_BIT)
                     rx_st_r <= ST_STOP;
               end
            ST_STOP:
               if (rx_at_last)
                  rx_st_r <= ST_IDLE;
            default:
               rx_st_r <= ST_IDLE;
         endcase
      end
   end

   // Holding register; a byte arriving unread overwrites and flags overrun
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_data_r <= 8'h00;
         rx_full_r <= 1'b0;
         rx_ovr_r  <= 1'b0;
      end
      else if (rx_stop_hit)
      begin
         rx_data_r <= rx_shift_r;
         rx_full_r <= 1'b1;
         rx_ovr_r  <= rx_full_r & ~rx_rd;
      end
      else if (rx_rd)
      begin
         rx_full_r <= 1'b0;
         rx_ovr_r  <= 1'b0;
      end
   end

   // Interrupt delay: 9 ticks normally, 19 for the first byte in FIFO mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_dly_r     <= DLY_ZERO;
         rx_dly_run_r <= 1'b0;
         rx_irq_r     <= 1'b0;
      end
      else
      begin
         if (rx_stop_hit)
         begin
            rx_dly_r     <= rx_first ? RX_DLY_FIFO : RX_DLY_PLAIN;
            rx_dly_run_r <= 1'b1;
         end
         else if (rx_dly_done)
            rx_dly_run_r <= 1'b0;
         else if (rx_dly_run_r && sample_tick)
            rx_dly_r <= 5'(rx_dly_r - 1'b1);
         // Set wins over a read in the same cycle
         if (rx_dly_done)
            rx_irq_r <= 1'b1;
         else if (rx_rd)
            rx_irq_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmit FIFO; its ready is the host's ready, so a full FIFO stalls
   uedm_fifo_if #(.W(DATA_BITS)) tx_ff ();

   assign tx_ff.in_valid = tx_wr;
   assign tx_ff.in_data  = tx_data;

   uedm_fifo #(.W(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo
   (
      .clk (clk),
      .rst (rst),
      .f   (tx_ff.fifo)
   );

   ////////////////////////////////////////////////////////////////////
   // Transmitter
   uedm_line_state_t tx_st_r;
   logic [3:0]       tx_tick_r;
   logic [2:0]       tx_bit_r;
   logic [7:0]       tx_shift_r;
   logic             txd_r;
   logic             tx_empty_r;

   wire tx_load    = (tx_st_r == ST_IDLE) & transmit_shift_clock &
                     tx_ff.out_valid;
   wire tx_bit_end = transmit_shift_clock & (tx_tick_r == TICK_LAST);
   wire tx_accept  = tx_wr & tx_ff.in_ready;
   // Empty judged at end of start bit: 17 ticks after a lone write
   wire tx_empty_set = (tx_st_r == ST_START) & tx_bit_end &
                       ~tx_ff.out_valid;

   assign tx_ff.out_ready = tx_load;

   // Shift sequencer, LSB first, one stop bit
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_st_r    <= ST_IDLE;
         tx_tick_r  <= TICK_ZERO;
         tx_bit_r   <= BIT_ZERO;
         tx_shift_r <= 8'h00;
         txd_r      <= 1'b1;
      end
      else
      begin
         if (transmit_shift_clock)
            tx_tick_r <= 4'(tx_tick_r + 1'b1);
         case (tx_st_r)
            ST_IDLE:
               if (tx_load)
               begin
                  tx_st_r    <= ST_START;
                  tx_shift_r <= tx_ff.out_data;
                  tx_tick_r  <= TICK_ZERO;
                  txd_r      <= 1'b0;
               end
            ST_START:
               if (tx_bit_end)
               begin
                  tx_st_r  <= ST_DATA;
                  tx_bit_r <= BIT_ZERO;
                  txd_r    <= tx_shift_r[0];
               end
            ST_DATA:
               if (tx_bit_end)
               begin
                  tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                  tx_bit_r   <= 3'(tx_bit_r + 1'b1);
                  txd_r      <= (tx_bit_r == LAST_BIT) ? 1'b1 : tx_shift_r[1];
                  if (tx_bit_r == LAST_BIT)
                     tx_st_r <= ST_STOP;
               end
            ST_STOP:
               if (tx_bit_end)
                  tx_st_r <= ST_IDLE;
            default:
               tx_st_r <= ST_IDLE;
         endcase
      end
   end

   // Transmit-empty interrupt; set wins over a write in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         tx_empty_r <= 1'b0;
      else if (tx_empty_set)
         tx_empty_r <= 1'b1;
      else if (tx_accept)
         tx_empty_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // DMA ready signalling, active low
   logic rxrdy_n_r;
   logic txrdy_n_r;

   wire rx_m1 = uedm_rx_mode1(fifo_enable_bit, dma_mode_select_bit);
   wire tx_m1 = uedm_tx_mode1(fifo_enable_bit, dma_mode_select_bit);
   // Mode 1 receive waits for the interrupt point; mode 0 any data
   wire rxrdy_nxt = rx_m1 ? (rx_full_r & rx_irq_r) : rx_full_r;
   // Mode 1 transmit: room left; mode 0: nothing queued at all
   wire txrdy_nxt = tx_m1 ? tx_ff.in_ready :
                    (~tx_ff.out_valid & ~tx_load);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rxrdy_n_r <= 1'b1;
         txrdy_n_r <= 1'b1;
      end
      else
      begin
         rxrdy_n_r <= ~rxrdy_nxt;
         txrdy_n_r <= ~txrdy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Modem status: deltas are sticky, a change wins over a clearing read
   logic [3:0] modem_prev_r;
   logic [3:0] modem_delta_r;
   logic       modem_irq_r;

   wire [3:0] modem_chg = modem_in ^ modem_prev_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         modem_prev_r  <= MODEM_RESET[MODEM_LEVEL_LSB +: 4];
         modem_delta_r <= MODEM_RESET[MODEM_DELTA_LSB +: 4];
         modem_irq_r   <= 1'b0;
      end
      else
      begin
         modem_prev_r  <= modem_in;
         modem_delta_r <= modem_chg |
                          (modem_status_rd ? 4'h0 : modem_delta_r);
         if (modem_chg != 4'h0)
            modem_irq_r <= 1'b1;
         else if (modem_status_rd)
            modem_irq_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output drive
   assign txd                    = txd_r;
   assign tx_ready               = tx_ff.in_ready;
   assign rx_data                = rx_data_r;
   assign rx_overrun             = rx_ovr_r;
   assign modem_status_register  = {modem_prev_r, modem_delta_r};
   assign rx_irq                 = rx_irq_r;
   assign transmit_holding_empty = tx_empty_r;
   assign modem_irq              = modem_irq_r;
   assign rxrdy_n                = rxrdy_n_r;
   assign txrdy_n                = txrdy_n_r;
endmodule // uedm_top

//--- verification/uedm_checker.sv
// Port-level checker for the serial event timing block
`timescale 1ns/1ps
module uedm_checker
#(
   parameter int SAMPLE_DIV = uedm_pkg::SAMPLE_DIV_DEFAULT
)
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       rxd,
   input wire logic       txd,
   input wire logic       tx_wr,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   input wire logic       rx_rd,
   input wire logic [7:0] rx_data,
   input wire logic       rx_overrun,
   input wire logic       modem_status_rd,
   input wire logic [3:0] modem_in,
   input wire logic [7:0] modem_status_register,
   input wire logic       fifo_enable_bit,
   input wire logic       dma_mode_select_bit,
   input wire logic       rx_irq,
   input wire logic       transmit_holding_empty,
   input wire logic       modem_irq,
   input wire logic       rxrdy_n,
   input wire logic       txrdy_n
);
   localparam int BITC = 16 * SAMPLE_DIV;
   int unsigned hold_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////
   // Clocks since txd last moved; starts full so the first start is legal
   always_ff @(posedge clk)
   begin
      if (rst)
         hold_r <= BITC;
      else if ($changed(txd))
         hold_r <= 0;
      else if (hold_r < BITC)
         hold_r <= hold_r + 1;
   end

   // Mode flags change between tests; $past guards keep mode changes out
   AST_TX_BIT_LEN:
      assert property ($changed(txd) |-> hold_r >= BITC - 1)
      else $error("txd level shorter than one bit");
   AST_RX_DMA_M1:
      assert property ($past(fifo_enable_bit && dma_mode_select_bit)
         && !rxrdy_n |-> $past(rx_irq))
      else $error("rx dma mode 1 ready without interrupt");
   AST_TX_DMA_M1:
      assert property (!$past(rst) && dma_mode_select_bit
         && $past(dma_mode_select_bit) |-> txrdy_n == !$past(tx_ready))
      else $error("tx dma mode 1 ready does not follow space");
   AST_TX_DMA_M0:
      assert property (!dma_mode_select_bit && !$past(dma_mode_select_bit)
         && !txrdy_n |-> $past(tx_ready))
      else $error("tx dma mode 0 ready while full");
   AST_MODEM_SET:
      assert property (!$past(rst) && modem_in != $past(modem_in)
         |=> modem_irq && modem_status_register[3:0] != 4'h0)
      else $error("modem change did not raise interrupt");
   AST_MODEM_LEVEL:
      assert property (!$past(rst)
         |-> modem_status_register[7:4] == $past(modem_in))
      else $error("modem level bits wrong");
   AST_MODEM_CLR:
      assert property (!$past(rst) && modem_status_rd
         && modem_in == $past(modem_in)
         |=> !modem_irq && modem_status_register[3:0] == 4'h0)
      else $error("modem status read did not clear");
   AST_RX_IRQ_STOP:
      assert property (!fifo_enable_bit && $rose(rx_irq) |-> rxd)
      else $error("receive interrupt rose outside stop bit");
   AST_TRANSMIT_HOLDING_EMPTY_CLR:
      assert property (tx_wr && tx_ready |=> !transmit_holding_empty)
      else $error("write did not clear transmit empty");
endmodule // uedm_checker

bind uedm_top uedm_checker #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.*);

//--- verification/uedm_line_model.sv
// Line-side model: frames into rxd, decodes txd into a queue
`timescale 1ns/1ps
module uedm_line_model
#(
   parameter int SD = 4
)
(
   input wire logic clk,
   input wire logic txd,
   output logic     rxd
);
   localparam int BITC = 16 * SD;
   logic [7:0] got_q[$];
   logic       stop_mark;
   logic [7:0] sh;

   ////////////////////////////////////////
   // Line idles high like a real pull-up
   initial
   begin
      rxd = 1'b1;
      stop_mark = 1'b0;
   end

   // One 8N1 frame, LSB first; stop_mark flags the stop bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         stop_mark = (i == 9);
         rxd = f[i];
         repeat (BITC) @(negedge clk);
      end
      stop_mark = 1'b0;
   endtask

   // Samples txd mid-bit; a short bit would shift the byte
   initial
   begin
      forever
      begin
         @(negedge txd);
         repeat (BITC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BITC) @(posedge clk);
            sh[i] = txd;
         end
         repeat (BITC) @(posedge clk);
         got_q.push_back(sh);
      end
   end
endmodule // uedm_line_model

//--- verification/tb_top.sv
// Self-checking bench for the serial event timing block
`timescale 1ns/1ps
module tb_top;
   import uedm_pkg::*;
   localparam int SD = 4;
   localparam int BITC = 16 * SD;
   logic       clk, rst, rxd, txd, tx_wr, tx_ready, rx_rd, rx_overrun;
   logic       modem_status_rd, fe, dms, rx_irq, tx_empty, modem_irq;
   logic       rxrdy_n, txrdy_n;
   logic [7:0] tx_data, rx_data, mstat;
   logic [3:0] modem_in;
   int         mismatches, check_count, cycles;

   ////////////////////////////////////////
   // Short tick divider keeps frames cheap to simulate
   uedm_top #(.SAMPLE_DIV(SD)) dut (
      .clk(clk), .rst(rst), .rxd(rxd), .txd(txd), .tx_wr(tx_wr),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_rd(rx_rd),
      .rx_data(rx_data), .rx_overrun(rx_overrun),
      .modem_status_rd(modem_status_rd),
      .modem_in(modem_in), .modem_status_register(mstat),
      .fifo_enable_bit(fe), .dma_mode_select_bit(dms), .rx_irq(rx_irq),
      .transmit_holding_empty(tx_empty), .modem_irq(modem_irq),
      .rxrdy_n(rxrdy_n), .txrdy_n(txrdy_n));
   uedm_line_model #(.SD(SD)) line (.clk(clk), .txd(txd), .rxd(rxd));

   // Clock and hang guard
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////
   // Receive one byte, time the interrupt from stop start, watch DMA
   task automatic t_rx(input logic f, input logic d, input logic [7:0] b);
      int   n;
      logic early;
      n = 0;
      early = 0;
      fe = f;
      dms = d;
      fork
         line.send(b);
         begin
            wait (line.stop_mark === 1'b1);
            while (rx_irq !== 1'b1 && n < 40 * SD)
            begin
               @(negedge clk);
               n++;
               if (rxrdy_n === 1'b0 && rx_irq !== 1'b1)
                  early = 1;
            end
         end
      join
      chk(rx_data, b);
      chk(n <= (f ? 20 : 17) * SD && n >= (f ? 18 : 7) * SD, 1);
      chk(early, !(f & d));
      rx_rd = 1;
      @(negedge clk);
      rx_rd = 0;
      @(negedge clk);
      chk(rx_irq, 0);
   endtask

   // Two bytes with no read between: overrun flagged, newest byte kept
   task automatic t_ovr();
      fe = 1;
      dms = 0;
      line.send(8'h66);
      line.send(8'h99);
      repeat (BITC) @(negedge clk);
      chk(rx_overrun, 1);
      chk(rx_data, 8'h99);
      chk(rx_irq, 1);
      rx_rd = 1;
      @(negedge clk);
      rx_rd = 0;
      @(negedge clk);
      chk({rx_overrun, rx_irq, rxrdy_n}, 3'h1);
   endtask

   // One byte from idle: empty interrupt window and line content
   task automatic t_tx(input logic d, input logic [7:0] b);
      int n;
      n = 0;
      dms = d;
      tx_data = b;
      tx_wr = 1;
      @(negedge clk);
      tx_wr = 0;
      while (tx_empty !== 1'b1 && n < 40 * SD)
      begin
         @(negedge clk);
         n++;
      end
      chk(n >= 16 * SD - 1 && n <= 24 * SD + 4, 1);
      repeat (10 * BITC) @(negedge clk);
      chk(txrdy_n, 0);
      chk(line.got_q.size(), 1);
      chk(line.got_q.pop_front(), b);
   endtask

   // Fill the transmit buffer, try one refused write, then drain
   task automatic t_fill();
      int n;
      n = 0;
      dms = 1;
      tx_wr = 1;
      while (tx_ready === 1'b1 && n < 40)
      begin
         tx_data = 8'h10 + 8'(n);
         @(negedge clk);
         n++;
      end
      tx_data = 8'hEE;
      @(negedge clk);
      tx_wr = 0;
      @(negedge clk);
      chk(txrdy_n, 1);
      chk(n >= 17 && n <= 18, 1);
      repeat ((n + 1) * 10 * BITC) @(negedge clk);
      chk(line.got_q.size(), n);
      for (int i = 0; i < n; i++)
         chk(line.got_q.pop_front(), 8'h10 + 8'(i));
   endtask

   // Toggle each modem input, then acknowledge by a status read
   task automatic t_modem();
      for (int i = 0; i < 4; i++)
      begin
         modem_in[i] = ~modem_in[i];
         repeat (2) @(negedge clk);
         chk(modem_irq, 1);
         chk(mstat, {modem_in, 4'h0} | (8'h01 << i));
         modem_status_rd = 1;
         @(negedge clk);
         modem_status_rd = 0;
         @(negedge clk);
         chk({modem_irq, mstat[3:0]}, 0);
      end
      // A change in the clearing read's own cycle must still be flagged
      modem_in[0] = ~modem_in[0];
      modem_status_rd = 1;
      @(negedge clk);
      modem_status_rd = 0;
      chk(modem_irq, 1);
      chk(mstat[3:0], 4'h1);
      @(negedge clk);
      modem_status_rd = 1;
      @(negedge clk);
      modem_status_rd = 0;
      @(negedge clk);
      chk({modem_irq, mstat[3:0]}, 0);
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      clk = 0;
      rst = 1;
      tx_wr = 0;
      tx_data = 0;
      rx_rd = 0;
      modem_status_rd = 0;
      modem_in = 0;
      fe = 0;
      dms = 0;
      repeat (16) @(negedge clk);
      rst = 0;
      @(negedge clk);
      chk({txd, tx_empty, rx_irq, modem_irq, rxrdy_n}, 5'h11);
      t_rx(0, 0, 8'hA5);
      t_rx(0, 1, 8'h3C);
      t_rx(1, 0, 8'h81);
      t_rx(1, 1, 8'h5A);
      t_ovr();
      t_tx(0, 8'hC3);
      t_tx(1, 8'h96);
      t_fill();
      t_modem();
      t_modem();
      report_and_stop();
   end
endmodule // tb_top
